// ---- mmie_exec.sv ----
// Module: executor for clock select, index decrement, irq mask, wdt arm
// Operation
// [RL1] Opcode 29B selects RC main clock
// [RL2] Decrement index; skip next on result 15
// [RL3] Mask instruction clears the interrupt allow flag
// [RL4] Interrupts still effective one cycle after masking
// [RL5] Opcode 29C arms watchdog stop only
// [RL6] Skipped instruction executes as no-operation
`timescale 1ns/1ps
module mmie_exec (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_instr_valid,
   input wire logic [9:0] i_instr,
   input wire logic i_irq_allow_set,
   input wire logic i_index_load,
   input wire logic [3:0] i_index_data,
   input wire logic i_wdt_arm_clear,
   output logic [3:0] o_index,
   output logic o_irq_allow_flag,
   output logic o_irq_effective,
   output logic o_rc_clock_sel,
   output logic o_wdt_stop_armed,
   output logic o_skip_pending,
   output logic o_carry_write
);
   ////////////////////////////////////////////////////////////////////
   // Decode path

   // Decoded word reaches the state groups over the local interface
   mmie_dec_if dif ();

   // Skip state comes first, the decode squash below reads it
   logic skip_r;
   logic skip_nxt;
   logic exec_valid;

   // A fetch that lands while a skip is pending never decodes
   assign exec_valid = i_instr_valid & ~skip_r; // [RL6]

   // Opcode decoder; it only ever sees words that really execute
   mmie_decoder u_dec (
      .i_instr(i_instr),
      .i_valid(exec_valid),
      .dec(dif.dec)
   );

   ////////////////////////////////////////////////////////////////////
   // Per-instruction strobes

   // One strobe per kind, each high for the single executing cycle
   logic do_rc;
   logic do_dec;
   logic do_mask;
   logic do_wdt;

   // Split the one-hot kind once; each state group reads one strobe
   always_comb
   begin
      do_rc = 1'h0;
      do_dec = 1'h0;
      do_mask = 1'h0;
      do_wdt = 1'h0;
      unique case (dif.kind)
         mmie_pkg::KIND_NONE:
         begin
            // Unknown or squashed word: no strobe fires
         end
         mmie_pkg::KIND_RC_CLOCK:
            do_rc = 1'h1; // [RL1]
         mmie_pkg::KIND_DEC_INDEX:
            do_dec = 1'h1; // [RL2]
         mmie_pkg::KIND_MASK_IRQ:
            do_mask = 1'h1; // [RL3]
         mmie_pkg::KIND_WDT_ARM:
            do_wdt = 1'h1; // [RL5]
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Index register

   logic [3:0] index_r;
   logic [3:0] index_nxt;

   // Index minus one; shared by the index update and the skip test
   function automatic logic [3:0] index_minus_one(input logic [3:0] v);
      return v - 4'h1;
   endfunction

   // Decrement wins over an external load landing in the same slot
   always_comb
   begin
      index_nxt = index_r;
      if (i_index_load)
         index_nxt = i_index_data;
      if (do_dec)
         index_nxt = index_minus_one(index_r); // [RL2]
   end

   // Index register; 0 wraps to 15 by plain 4-bit arithmetic
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         index_r <= mmie_pkg::INDEX_RST;
      else
         index_r <= index_nxt;
   end

   ////////////////////////////////////////////////////////////////////
   // Skip control

   // Decrement result that orders a skip of the next fetched word
   logic dec_wraps;

   assign dec_wraps =
      (index_minus_one(index_r) == mmie_pkg::INDEX_WRAP); // [RL2]

   // A skip waits through idle cycles and covers exactly one fetch;
   // fetch gaps are legal, so it must never time out on its own
   always_comb
   begin
      skip_nxt = skip_r;
      if (i_instr_valid)
         skip_nxt = 1'h0; // [RL6]
      if (do_dec)
         skip_nxt = dec_wraps; // [RL2]
   end

   // Skip flag register
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         skip_r <= mmie_pkg::SKIP_RST;
      else
         skip_r <= skip_nxt;
   end

   ////////////////////////////////////////////////////////////////////
   // Interrupt allow flag and masking lag

   logic irq_allow_r;
   logic irq_allow_nxt;
   logic [1:0] lag_r;
   logic [1:0] lag_nxt;

   // Mask wins over a set in the same slot, it is the instruction.
   // The lag only starts when interrupts were allowed: masking an
   // already masked core must not open a one-cycle window.
   always_comb
   begin
      irq_allow_nxt = irq_allow_r | i_irq_allow_set;
      lag_nxt = lag_r;
      if (lag_r != 2'h0)
         lag_nxt = lag_r - 2'h1;
      if (do_mask)
      begin
         irq_allow_nxt = 1'h0; // [RL3]
         lag_nxt = irq_allow_r ? mmie_pkg::IRQ_MASK_LAG : 2'h0; // [RL4]
      end
   end

   // Flag and lag counter registers
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         irq_allow_r <= mmie_pkg::IRQ_ALLOW_RST;
         lag_r <= mmie_pkg::LAG_RST;
      end
      else
      begin
         irq_allow_r <= irq_allow_nxt;
         lag_r <= lag_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Main clock source select

   logic rc_sel_r;
   logic rc_sel_nxt;

   // Sticky: only reset hands the main clock back to the main input
   always_comb
   begin
      rc_sel_nxt = rc_sel_r;
      if (do_rc)
         rc_sel_nxt = 1'h1; // [RL1]
   end

   // Select register; the oscillator switch itself lives outside
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         rc_sel_r <= mmie_pkg::RC_CLOCK_RST;
      else
         rc_sel_r <= rc_sel_nxt;
   end

   ////////////////////////////////////////////////////////////////////
   // Watchdog stop arm

   logic wdt_arm_r;
   logic wdt_arm_nxt;

   // Arm beats a clear in the same slot so the request is not lost;
   // the stop itself is completed by the power-down word elsewhere
   always_comb
   begin
      wdt_arm_nxt = wdt_arm_r;
      if (i_wdt_arm_clear)
         wdt_arm_nxt = 1'h0;
      if (do_wdt)
         wdt_arm_nxt = 1'h1; // [RL5]
   end

   // Arm register
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         wdt_arm_r <= mmie_pkg::WDT_ARM_RST;
      else
         wdt_arm_r <= wdt_arm_nxt;
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs

   // From registers, except effective (flag OR lag) and carry (tied 0); none of these words touches carry
   assign o_index = index_r;
   assign o_irq_allow_flag = irq_allow_r;
   assign o_irq_effective = irq_allow_r | (lag_r != 2'h0); // [RL4]
   assign o_rc_clock_sel = rc_sel_r;
   assign o_wdt_stop_armed = wdt_arm_r;
   assign o_skip_pending = skip_r;
   assign o_carry_write = 1'h0; // [RL1] [RL3] [RL5]
endmodule // mmie_exec

// ---- mmie_pkg.sv ----
// Package: opcodes and constants for the misc instruction executor
package mmie_pkg;
   localparam int unsigned INSTR_W = 10;
   localparam int unsigned INDEX_W = 4;
   // Opcodes
   localparam logic [9:0] OP_SELECT_RC_CLOCK = 10'h29B;
   localparam logic [9:0] OP_DECREMENT_INDEX = 10'h017;
   localparam logic [9:0] OP_MASK_INTERRUPTS = 10'h004;
   localparam logic [9:0] OP_WATCHDOG_STOP_ARM = 10'h29C;
   // Index value that signals a wrap
   localparam logic [3:0] INDEX_WRAP = 4'hF;
   // Machine cycles that interrupts stay effective after masking
   localparam logic [1:0] IRQ_MASK_LAG = 2'h1;
   // Reset values
   localparam logic [3:0] INDEX_RST = 4'h0;
   localparam logic IRQ_ALLOW_RST = 1'b0;
   localparam logic RC_CLOCK_RST = 1'b0;
   localparam logic WDT_ARM_RST = 1'b0;
   localparam logic [1:0] LAG_RST = 2'h0;
   localparam logic SKIP_RST = 1'b0;
   // Decoded instruction kinds
   typedef enum logic [4:0] {
      KIND_NONE = 5'b00001,
      KIND_RC_CLOCK = 5'b00010,
      KIND_DEC_INDEX = 5'b00100,
      KIND_MASK_IRQ = 5'b01000,
      KIND_WDT_ARM = 5'b10000
   } mmie_kind_t;
endpackage

// ---- mmie_dec_if.sv ----
// Interface: decoded instruction between decoder and executor
`timescale 1ns/1ps
interface mmie_dec_if;
   mmie_pkg::mmie_kind_t kind;
   modport dec (output kind);
   modport exe (input kind);
endinterface

// ---- mmie_decoder.sv ----
// Module: opcode decoder for the misc instructions
`timescale 1ns/1ps
module mmie_decoder (
   input wire logic [9:0] i_instr,
   input wire logic i_valid,
   mmie_dec_if.dec dec
);
   ////////////////////////////////////////////////////////////////////
   // Pure decode; a skipped slot is squashed by the caller
   always_comb
   begin
      dec.kind = mmie_pkg::KIND_NONE;
      if (i_valid)
      begin
         unique case (i_instr)
            mmie_pkg::OP_SELECT_RC_CLOCK: dec.kind = mmie_pkg::KIND_RC_CLOCK;
            mmie_pkg::OP_DECREMENT_INDEX: dec.kind = mmie_pkg::KIND_DEC_INDEX;
            mmie_pkg::OP_MASK_INTERRUPTS: dec.kind = mmie_pkg::KIND_MASK_IRQ;
            mmie_pkg::OP_WATCHDOG_STOP_ARM: dec.kind = mmie_pkg::KIND_WDT_ARM;
            default: dec.kind = mmie_pkg::KIND_NONE;
         endcase
      end
   end
endmodule // mmie_decoder

// ---- mmie_exec_props.sv ----
// Checker: timing properties of the misc instruction executor
`timescale 1ns/1ps
module mmie_props (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_instr_valid,
   input wire logic [9:0] i_instr,
   input wire logic i_index_load,
   input wire logic [3:0] o_index,
   input wire logic o_irq_allow_flag,
   input wire logic o_irq_effective,
   input wire logic o_rc_clock_sel,
   input wire logic o_wdt_stop_armed,
   input wire logic o_skip_pending
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   // A squashed fetch never counts as executed
   logic ex;
   assign ex = i_instr_valid && !o_skip_pending;
   a_rc_select: assert property (
      ex && i_instr == mmie_pkg::OP_SELECT_RC_CLOCK |=> o_rc_clock_sel)
      else $error("rc select missing");
   a_dec_index: assert property (
      ex && i_instr == mmie_pkg::OP_DECREMENT_INDEX |=>
      o_index == $past(o_index) - 4'h1 &&
      o_skip_pending == ($past(o_index) == 4'h0))
      else $error("index decrement or skip wrong");
   a_mask_flag: assert property (
      ex && i_instr == mmie_pkg::OP_MASK_INTERRUPTS |=> !o_irq_allow_flag)
      else $error("allow flag not cleared");
   a_mask_lag: assert property (
      ex && i_instr == mmie_pkg::OP_MASK_INTERRUPTS && o_irq_allow_flag
      |=> o_irq_effective)
      else $error("interrupts blocked too early");
   a_wdt_arm: assert property (
      ex && i_instr == mmie_pkg::OP_WATCHDOG_STOP_ARM |=> o_wdt_stop_armed)
      else $error("watchdog stop not armed");
   a_mask_block: assert property (
      ex && i_instr == mmie_pkg::OP_MASK_INTERRUPTS |->
      ##2 o_irq_effective == o_irq_allow_flag)
      else $error("interrupts not blocked after the lag");
   // An external index load may land in a skipped slot; it is no word
   a_skip_noop: assert property (
      i_instr_valid && o_skip_pending && !i_index_load |=>
      !o_skip_pending && $stable(o_rc_clock_sel) && $stable(o_index) &&
      !$rose(o_wdt_stop_armed))
      else $error("skipped word had an effect");
endmodule // mmie_props
bind mmie_exec mmie_props u_props (
   .i_ref_clk(i_ref_clk),
   .i_rst(i_rst),
   .i_instr_valid(i_instr_valid),
   .i_instr(i_instr),
   .i_index_load(i_index_load),
   .o_index(o_index),
   .o_irq_allow_flag(o_irq_allow_flag),
   .o_irq_effective(o_irq_effective),
   .o_rc_clock_sel(o_rc_clock_sel),
   .o_wdt_stop_armed(o_wdt_stop_armed),
   .o_skip_pending(o_skip_pending)
);

// ---- mmie_exec_tb.sv ----
// Testbench: self-checking run of the misc instruction executor
`timescale 1ns/1ps
module mmie_exec_tb;
   logic clk = 0, rst = 1, vld = 0, st = 0, ld = 0, clr = 0;
   logic [9:0] ins = 10'h000;
   logic [3:0] dat = 4'h1, idx;
   logic flg, eff, rc, wdt, skp, cyw;
   int error_cnt = 0, tests_run = 0, cyc = 0;
   mmie_exec u_dut (.i_ref_clk(clk), .i_rst(rst), .i_instr_valid(vld),
      .i_instr(ins), .i_irq_allow_set(st), .i_index_load(ld),
      .i_index_data(dat), .i_wdt_arm_clear(clr), .o_index(idx),
      .o_irq_allow_flag(flg), .o_irq_effective(eff), .o_rc_clock_sel(rc),
      .o_wdt_stop_armed(wdt), .o_skip_pending(skp), .o_carry_write(cyw));
   always #10 clk = ~clk;
   // Hang guard, far above the few dozen cycles needed
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         error_cnt++;
         final_report();
      end
   end
   // Compare of the 4-bit index; !== so an unknown never passes
   task automatic chk_index(string nm, logic [3:0] e, logic [3:0] g);
      tests_run++;
      if (g !== e)
      begin
         error_cnt++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask
   // Compare of a single flag output
   task automatic chk_flag(string nm, logic e, logic g);
      tests_run++;
      if (g !== e)
      begin
         error_cnt++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask
   // One pulse cycle; idle gap keeps each strobe at one write per step
   task automatic go(logic v, logic [9:0] w, logic s = 0, logic l = 0,
      logic c = 0);
      @(negedge clk);
      {vld, ins, st, ld, clr} = {v, w, s, l, c};
      @(negedge clk);
      {vld, st, ld, clr} = 4'h0;
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // First release of reset: every register starts cleared
   task automatic test_reset();
      repeat (4) @(posedge clk);
      @(negedge clk) rst = 1'h0;
      chk_index("index", mmie_pkg::INDEX_RST, idx);
      chk_flag("flag", mmie_pkg::IRQ_ALLOW_RST, flg);
      chk_flag("effective", 1'h0, eff);
      chk_flag("rc", mmie_pkg::RC_CLOCK_RST, rc);
      chk_flag("wdt", mmie_pkg::WDT_ARM_RST, wdt);
      chk_flag("skip", 1'h0, skp);
      $display("reset done");
   endtask
   // Wrap skips the next word, a clock select and then a watchdog arm; no wrap, no skip
   task automatic test_decrement();
      go(1'h1, mmie_pkg::OP_DECREMENT_INDEX);
      chk_index("index", 4'hF, idx);
      chk_flag("skip", 1'h1, skp);
      go(1'h1, mmie_pkg::OP_SELECT_RC_CLOCK);
      chk_flag("rc", 1'h0, rc);
      chk_flag("skip", 1'h0, skp);
      dat = 4'h0;
      go(1'h0, 10'h000, 1'h0, 1'h1);
      go(1'h1, mmie_pkg::OP_DECREMENT_INDEX);
      chk_flag("skip", 1'h1, skp);
      go(1'h1, mmie_pkg::OP_WATCHDOG_STOP_ARM);
      chk_flag("wdt", 1'h0, wdt);
      chk_flag("skip", 1'h0, skp);
      dat = 4'h1;
      go(1'h0, 10'h000, 1'h0, 1'h1);
      go(1'h1, mmie_pkg::OP_DECREMENT_INDEX);
      chk_index("index", 4'h0, idx);
      chk_flag("skip", 1'h0, skp);
      $display("decrement done");
   endtask
   // Unknown word first, then the clock select itself
   task automatic test_rc_clock();
      go(1'h1, 10'h3FF);
      chk_flag("rc", 1'h0, rc);
      chk_index("index", 4'h0, idx);
      go(1'h1, mmie_pkg::OP_SELECT_RC_CLOCK);
      chk_flag("rc", 1'h1, rc);
      chk_flag("skip", 1'h0, skp);
      chk_flag("carry", 1'h0, cyw);
      $display("rc select done");
   endtask
   // Lag only when interrupts were allowed before the mask
   task automatic test_mask();
      go(1'h0, 10'h000, 1'h1);
      chk_flag("flag", 1'h1, flg);
      go(1'h1, mmie_pkg::OP_MASK_INTERRUPTS);
      chk_flag("flag", 1'h0, flg);
      chk_flag("carry", 1'h0, cyw);
      chk_flag("effective", 1'h1, eff);
      @(negedge clk);
      chk_flag("effective", 1'h0, eff);
      go(1'h1, mmie_pkg::OP_MASK_INTERRUPTS);
      chk_flag("effective", 1'h0, eff);
      chk_flag("skip", 1'h0, skp);
      $display("mask done");
   endtask
   // Arm, then the external clear that follows a power-down
   task automatic test_watchdog();
      go(1'h1, mmie_pkg::OP_WATCHDOG_STOP_ARM);
      chk_flag("wdt", 1'h1, wdt);
      chk_flag("carry", 1'h0, cyw);
      chk_flag("skip", 1'h0, skp);
      go(1'h0, 10'h000, 1'h0, 1'h0, 1'h1);
      chk_flag("wdt", 1'h0, wdt);
      $display("watchdog done");
   endtask
   // Mid-run reset drops the sticky clock select, arm and index
   task automatic test_second_reset();
      go(1'h0, 10'h000, 1'h0, 1'h1);
      go(1'h1, mmie_pkg::OP_WATCHDOG_STOP_ARM);
      chk_flag("wdt", 1'h1, wdt);
      @(negedge clk) rst = 1'h1;
      @(negedge clk) rst = 1'h0;
      chk_flag("rc", mmie_pkg::RC_CLOCK_RST, rc);
      chk_flag("wdt", mmie_pkg::WDT_ARM_RST, wdt);
      chk_index("index", mmie_pkg::INDEX_RST, idx);
      chk_flag("effective", 1'h0, eff);
      $display("second reset done");
   endtask
   initial
   begin
      test_reset();
      test_decrement();
      test_rc_clock();
      test_mask();
      test_watchdog();
      test_second_reset();
      final_report();
   end
endmodule // mmie_exec_tb
